// File: hw/pmh_macrocell_host.sv
`timescale 1ns/1ns
// Output and input macrocells with host load, read back and pin enables
module pmh_macrocell_host #(
  parameter logic [7:0] WINDOW_BASE = 8'h00
) (
  input  wire logic                            clk_sys,
  input  wire logic                            resetn,
  // Host bus pins (multiplexed 8-bit)
  input  wire logic [7:0]                      address_data_in,
  output logic      [7:0]                      address_data_out,
  output logic                                 address_data_oe,
  input  wire logic [7:0]                      address_high,
  input  wire logic                            address_strobe,
  input  wire logic                            bus_control_pin_0,
  input  wire logic                            bus_control_pin_1,
  input  wire logic                            bus_control_pin_2,
  input  wire logic                            external_clock_input,
  input  wire logic [pmh_pkg::IN_CELLS-1:0]    port_in,
  // Configuration bits
  input  wire logic [1:0]                      cfg_bus_type,
  input  wire logic                            cfg_load_level,
  input  wire logic [pmh_pkg::OUT_CELLS-1:0]   cfg_cell_comb,
  input  wire logic [pmh_pkg::OUT_CELLS-1:0]   cfg_cell_ext_clk,
  input  wire logic [pmh_pkg::OUT_CELLS-1:0]   cfg_cell_has_oe_eq,
  input  wire logic [pmh_pkg::OUT_CELLS-1:0]   cfg_cell_node,
  input  wire logic [pmh_pkg::OUT_CELLS-1:0]   direction_bits,
  input  wire logic [2*pmh_pkg::IN_CELLS-1:0]  cfg_in_mode,
  input  wire logic [pmh_pkg::NIBBLES-1:0]     cfg_in_use_strobe,
  input  wire logic [4*pmh_pkg::OUT_CELLS-1:0] cfg_borrow_req,
  // Product terms from the AND array
  input  wire logic [pmh_pkg::OUT_CELLS-1:0]   pt_d,
  input  wire logic [pmh_pkg::OUT_CELLS-1:0]   pt_clk,
  input  wire logic [pmh_pkg::OUT_CELLS-1:0]   pt_preset,
  input  wire logic [pmh_pkg::OUT_CELLS-1:0]   pt_clear,
  input  wire logic [pmh_pkg::OUT_CELLS-1:0]   pt_comb,
  input  wire logic [pmh_pkg::OUT_CELLS-1:0]   pt_oe,
  input  wire logic [pmh_pkg::NIBBLES-1:0]     pt_in_enable,
  // To pins and to the logic array
  output logic      [pmh_pkg::OUT_CELLS-1:0]   cell_pin_out,
  output logic      [pmh_pkg::OUT_CELLS-1:0]   cell_pin_oe,
  output logic      [pmh_pkg::OUT_CELLS-1:0]   cell_feedback,
  output logic      [pmh_pkg::IN_CELLS-1:0]    input_cell_out,
  output logic                                 control_pin_2_to_array,
  output logic                                 program_fetch_active,
  output logic      [pmh_pkg::OUT_CELLS-1:0]   cell_expanded
);
  import pmh_pkg::*;

  localparam int SYNC_W = 8 + 8 + 5 + IN_CELLS;
  // Idle pin pattern: strobe low, active-low control pins high, so no false strobe follows reset
  localparam logic [SYNC_W-1:0] PIN_IDLE = {{IN_CELLS{1'b0}}, 5'h0e, 16'h0000};

  // Pin synchroniser: three stages, a change counts once stages two and three agree
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] sync3_r;
  logic [SYNC_W-1:0] clean_r;
  logic [SYNC_W-1:0] clean_nxt;
  logic [SYNC_W-1:0] pins_raw;

  assign pins_raw = {port_in, external_clock_input, bus_control_pin_2, bus_control_pin_1,
                     bus_control_pin_0, address_strobe, address_high, address_data_in};

  always_comb begin
    for (int b = 0; b < SYNC_W; b++) begin
      clean_nxt[b] = (sync2_r[b] == sync3_r[b]) ? sync3_r[b] : clean_r[b];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync1_r <= PIN_IDLE;
      sync2_r <= PIN_IDLE;
      sync3_r <= PIN_IDLE;
      clean_r <= PIN_IDLE;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      clean_r <= clean_nxt;
    end
  end

  logic [7:0]          ad_c;
  logic [7:0]          ahi_c;
  logic                ale_c;
  logic                c0_n;
  logic                c1_n;
  logic                c2_n;
  logic                ext_clk_c;
  logic [IN_CELLS-1:0] port_c;

  assign ad_c      = clean_r[7:0];
  assign ahi_c     = clean_r[15:8];
  assign ale_c     = clean_r[16];
  assign c0_n      = clean_r[17];
  assign c1_n      = clean_r[18];
  assign c2_n      = clean_r[19];
  assign ext_clk_c = clean_r[20];
  assign port_c    = clean_r[SYNC_W-1:21];

  // Control pin roles per bus type; strobes are active low on the pins
  logic wr_act;
  logic rd_act;
  logic c2_free;

  always_comb begin
    wr_act  = !c0_n;
    rd_act  = 1'b0;
    c2_free = 1'b1;
    program_fetch_active = 1'b0;
    unique case (pmh_bus_t'(cfg_bus_type))
      PMH_BUS_MUX: begin
        rd_act  = !c1_n;
        c2_free = 1'b0;
        program_fetch_active = !c2_n;
      end
      PMH_BUS_FETCH_ONLY: begin
        program_fetch_active = !c1_n;
      end
      PMH_BUS_NO_FETCH: begin
        rd_act = !c1_n;
      end
      default: begin
        rd_act = !c1_n;
      end
    endcase
    control_pin_2_to_array = c2_free ? c2_n : 1'b0;
  end

  // Address latch: low byte and high byte held from the strobe's falling edge
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;
  logic        ale_prev_r;
  logic        wr_prev_r;
  logic        wr_trail;
  logic        win_hit;

  always_comb begin
    addr_nxt = addr_r;
    if (ale_prev_r && !ale_c) addr_nxt = {ahi_c, ad_c};
  end

  assign wr_trail = wr_prev_r && !wr_act;
  assign win_hit  = (addr_r[15:8] == WINDOW_BASE);

  // Host load strobes per group; level mode loads every cycle of the strobe
  logic load_now;
  logic ab_load;
  logic bc_load;

  assign load_now = cfg_load_level ? wr_act : wr_trail;
  assign ab_load  = load_now && win_hit && addr_r[7:0] == OFF_AB_CELLS;
  assign bc_load  = load_now && win_hit && addr_r[7:0] == OFF_BC_CELLS;

  // Mask registers are written once per strobe, at its trailing edge
  logic [7:0] mask_ab_r;
  logic [7:0] mask_bc_r;
  logic [7:0] mask_ab_nxt;
  logic [7:0] mask_bc_nxt;

  always_comb begin
    mask_ab_nxt = mask_ab_r;
    mask_bc_nxt = mask_bc_r;
    if (wr_trail && win_hit && addr_r[7:0] == OFF_AB_MASK) mask_ab_nxt = ad_c;
    if (wr_trail && win_hit && addr_r[7:0] == OFF_BC_MASK) mask_bc_nxt = ad_c;
  end

  // Term budget: over-limit cells take their D and combinational terms through one extra stage
  logic [OUT_CELLS-1:0] over_limit;
  logic [OUT_CELLS-1:0] pt_d_dly_r;
  logic [OUT_CELLS-1:0] pt_comb_dly_r;

  always_comb begin
    for (int i = 0; i < OUT_CELLS; i++) begin
      if (i < CELLS_PER_GROUP)
        over_limit[i] = cfg_borrow_req[4*i +: 4] > BORROW_AB;
      else if (i < CELLS_PER_GROUP + 4)
        over_limit[i] = cfg_borrow_req[4*i +: 4] > BORROW_BC_LO;
      else
        over_limit[i] = cfg_borrow_req[4*i +: 4] > BORROW_BC_HI;
    end
  end

  assign cell_expanded = over_limit;

  // Output cell flip-flops
  logic [OUT_CELLS-1:0] cell_q_r;
  logic [OUT_CELLS-1:0] cell_q_nxt;
  logic [OUT_CELLS-1:0] clk_prev_r;
  logic [OUT_CELLS-1:0] clk_src;
  logic [OUT_CELLS-1:0] host_load;
  logic [OUT_CELLS-1:0] d_eff;
  logic [OUT_CELLS-1:0] out_r;
  logic [OUT_CELLS-1:0] out_nxt;

  // Host load beats clear, preset and clock so software sees its own value
  always_comb begin
    cell_q_nxt = cell_q_r;
    for (int i = 0; i < OUT_CELLS; i++) begin
      clk_src[i] = cfg_cell_ext_clk[i] ? ext_clk_c : pt_clk[i];
      d_eff[i]   = over_limit[i] ? pt_d_dly_r[i] : pt_d[i];
      if (i < CELLS_PER_GROUP)
        host_load[i] = ab_load && !mask_ab_r[i];
      else
        host_load[i] = bc_load && !mask_bc_r[i-CELLS_PER_GROUP];
      if (host_load[i])
        cell_q_nxt[i] = ad_c[i % CELLS_PER_GROUP];
      else if (pt_clear[i])
        cell_q_nxt[i] = 1'b0;
      else if (pt_preset[i])
        cell_q_nxt[i] = 1'b1;
      else if (clk_src[i] && !clk_prev_r[i])
        cell_q_nxt[i] = d_eff[i];
      out_nxt[i] = cfg_cell_comb[i] ? (over_limit[i] ? pt_comb_dly_r[i] : pt_comb[i]) : cell_q_nxt[i];
    end
  end

  // Pin enable; a node never drives, an output with no equation always does
  always_comb begin
    for (int i = 0; i < OUT_CELLS; i++) begin
      if (cfg_cell_node[i])
        cell_pin_oe[i] = 1'b0;
      else if (!cfg_cell_has_oe_eq[i])
        cell_pin_oe[i] = 1'b1;
      else
        cell_pin_oe[i] = pt_oe[i] | direction_bits[i];
    end
  end

  assign cell_pin_out  = out_r;
  assign cell_feedback = out_r;

  // Input cells
  logic [IN_CELLS-1:0] in_q;

  pmh_input_bank u_inputs (
    .clk_sys              (clk_sys),
    .resetn               (resetn),
    .port_clean           (port_c),
    .nibble_pt            (pt_in_enable),
    .nibble_use_strobe    (cfg_in_use_strobe),
    .address_strobe_clean (ale_c),
    .cell_mode            (cfg_in_mode),
    .input_cell_q         (in_q)
  );

  assign input_cell_out = in_q;

  // Read back: data held in a flop, driven only while a read hits the window
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic       rd_hit;

  always_comb begin
    unique case (addr_r[7:0])
      OFF_AB_CELLS:  rdata_nxt = cell_q_r[7:0];
      OFF_BC_CELLS:  rdata_nxt = cell_q_r[15:8];
      OFF_AB_MASK:   rdata_nxt = mask_ab_r;
      OFF_BC_MASK:   rdata_nxt = mask_bc_r;
      OFF_IN_PORT_A: rdata_nxt = in_q[7:0];
      OFF_IN_PORT_B: rdata_nxt = in_q[15:8];
      OFF_IN_PORT_C: rdata_nxt = in_q[23:16];
      default:       rdata_nxt = 8'h00;
    endcase
  end

  // Unmapped offsets are not driven so another resource can answer
  assign rd_hit = win_hit && (addr_r[7:0] == OFF_AB_CELLS || addr_r[7:0] == OFF_BC_CELLS ||
                  addr_r[7:0] == OFF_AB_MASK || addr_r[7:0] == OFF_BC_MASK ||
                  addr_r[7:0] == OFF_IN_PORT_A || addr_r[7:0] == OFF_IN_PORT_B ||
                  addr_r[7:0] == OFF_IN_PORT_C);
  assign address_data_oe  = rd_act && rd_hit;
  assign address_data_out = rdata_r;

  // Register stage for the address latch, masks, output cells and read data
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      addr_r        <= 16'h0000;
      ale_prev_r    <= 1'b0;
      wr_prev_r     <= 1'b0;
      mask_ab_r     <= MASK_RESET;
      mask_bc_r     <= MASK_RESET;
      cell_q_r      <= {CELLS_RESET, CELLS_RESET};
      clk_prev_r    <= '0;
      out_r         <= '0;
      pt_d_dly_r    <= '0;
      pt_comb_dly_r <= '0;
      rdata_r       <= 8'h00;
    end else begin
      addr_r        <= addr_nxt;
      ale_prev_r    <= ale_c;
      wr_prev_r     <= wr_act;
      mask_ab_r     <= mask_ab_nxt;
      mask_bc_r     <= mask_bc_nxt;
      cell_q_r      <= cell_q_nxt;
      clk_prev_r    <= clk_src;
      out_r         <= out_nxt;
      pt_d_dly_r    <= pt_d;
      pt_comb_dly_r <= pt_comb;
      rdata_r       <= rdata_nxt;
    end
  end
endmodule

// File: hw/pmh_pkg.sv
// Summary of operation
// - Host load of all 16 output cells overrides
// - Output cells readable and writable in config window
// - Load at strobe trailing edge or level
// - One mask per group, resets to zero
// - Mask bit one blocks host load
// - Pin enable is product term OR direction bit
// - Output without enable equation always drives
// - Internal node releases pin, keeps feedback
// - Native and borrow term limits per group
// - Over-limit equations expand with extra delay
// - 24 input cells: latch, register or pass
// - Input cell clock: product term or strobe
// - One enable term per nibble
// - Input cells readable by host, feed array
// - Strobe-clocked input cells capture their port pins
// - Unused control pin 2 feeds logic array
// - Rising edge clock, active-high preset and clear
// - Cell n maps to data bit n mod 8
package pmh_pkg;
  localparam int CELLS_PER_GROUP = 8;
  localparam int OUT_CELLS       = 16;
  localparam int IN_CELLS        = 24;
  localparam int NIBBLES         = 6;
  // Register offsets inside the configuration window (low address byte)
  localparam logic [7:0] OFF_IN_PORT_A   = 8'h10;
  localparam logic [7:0] OFF_IN_PORT_B   = 8'h11;
  localparam logic [7:0] OFF_IN_PORT_C   = 8'h12;
  localparam logic [7:0] OFF_AB_CELLS    = 8'h20;
  localparam logic [7:0] OFF_BC_CELLS    = 8'h21;
  localparam logic [7:0] OFF_AB_MASK     = 8'h22;
  localparam logic [7:0] OFF_BC_MASK     = 8'h23;
  localparam logic [7:0] MASK_RESET      = 8'h00;
  localparam logic [7:0] CELLS_RESET     = 8'h00;
  // Product term budget per output cell
  localparam logic [3:0] NATIVE_AB       = 4'h3;
  localparam logic [3:0] NATIVE_BC       = 4'h4;
  localparam logic [3:0] BORROW_AB       = 4'h6;
  localparam logic [3:0] BORROW_BC_LO    = 4'h5;
  localparam logic [3:0] BORROW_BC_HI    = 4'h6;
  // Input cell modes
  typedef enum logic [1:0] {
    PMH_IN_PASS  = 2'b00,
    PMH_IN_LATCH = 2'b01,
    PMH_IN_REG   = 2'b11
  } pmh_in_mode_t;
  // Host bus types and use of the three control pins
  typedef enum logic [1:0] {
    PMH_BUS_MUX        = 2'b00,
    PMH_BUS_FETCH_ONLY = 2'b01,
    PMH_BUS_NO_FETCH   = 2'b11
  } pmh_bus_t;
endpackage

// File: hw/pmh_input_bank.sv
`timescale 1ns/1ns
// Twenty-four input cells, enables shared per nibble
module pmh_input_bank (
  input  wire logic                            clk_sys,
  input  wire logic                            resetn,
  input  wire logic [pmh_pkg::IN_CELLS-1:0]    port_clean,
  input  wire logic [pmh_pkg::NIBBLES-1:0]     nibble_pt,
  input  wire logic [pmh_pkg::NIBBLES-1:0]     nibble_use_strobe,
  input  wire logic                            address_strobe_clean,
  input  wire logic [2*pmh_pkg::IN_CELLS-1:0]  cell_mode,
  output logic      [pmh_pkg::IN_CELLS-1:0]    input_cell_q
);
  import pmh_pkg::*;

  logic [NIBBLES-1:0]  en_prev_r;
  logic [NIBBLES-1:0]  en_prev_nxt;
  logic [IN_CELLS-1:0] q_r;
  logic [IN_CELLS-1:0] q_nxt;
  logic [NIBBLES-1:0]  en_sel;

  // Per-nibble enable mux: array term or address strobe
  always_comb begin
    for (int n = 0; n < NIBBLES; n++) begin
      en_sel[n] = nibble_use_strobe[n] ? address_strobe_clean : nibble_pt[n];
    end
    en_prev_nxt = en_sel;
  end

  // Cell update; latch is transparent while enable is high
  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < IN_CELLS; i++) begin
      unique case (pmh_in_mode_t'(cell_mode[2*i +: 2]))
        PMH_IN_PASS:  q_nxt[i] = port_clean[i];
        PMH_IN_LATCH: if (en_sel[i/4]) q_nxt[i] = port_clean[i];
        PMH_IN_REG:   if (en_sel[i/4] && !en_prev_r[i/4]) q_nxt[i] = port_clean[i];
        default:      q_nxt[i] = port_clean[i];
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      q_r       <= '0;
      en_prev_r <= '0;
    end else begin
      q_r       <= q_nxt;
      en_prev_r <= en_prev_nxt;
    end
  end

  assign input_cell_q = q_r;
endmodule

// File: tb/pmh_macrocell_host_monitor.sv
`timescale 1ns/1ns
// Port-level checks on the macrocell host block
module pmh_macrocell_host_monitor (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        bus_control_pin_0,
  input wire logic        bus_control_pin_1,
  input wire logic        bus_control_pin_2,
  input wire logic        external_clock_input,
  input wire logic        address_data_oe,
  input wire logic        control_pin_2_to_array,
  input wire logic [1:0]  cfg_bus_type,
  input wire logic [15:0] cfg_cell_comb,
  input wire logic [15:0] cfg_cell_ext_clk,
  input wire logic [15:0] cfg_cell_has_oe_eq,
  input wire logic [15:0] cfg_cell_node,
  input wire logic [15:0] direction_bits,
  input wire logic [15:0] pt_preset,
  input wire logic [15:0] pt_clear,
  input wire logic [15:0] pt_oe,
  input wire logic [15:0] cell_pin_out,
  input wire logic [15:0] cell_pin_oe,
  input wire logic [15:0] cell_feedback,
  input wire logic [15:0] cell_expanded,
  input wire logic [63:0] cfg_borrow_req
);
  import pmh_pkg::*;
  logic [15:0] over_lim;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Borrow limit per cell; BC cells 0-3 may borrow one term less
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      over_lim[i] = cfg_borrow_req[4*i +: 4] > ((i >= 8 && i < 12) ? BORROW_BC_LO : BORROW_AB);
    end
  end
  // Pin enables are combinational, so they are checked in every cycle
  property p_node; (cell_pin_oe & cfg_cell_node) == 16'h0000; endproperty
  a_node: assert property (p_node) else $error("node cell drives its pin");
  property p_free_oe; (~cfg_cell_has_oe_eq & ~cfg_cell_node & ~cell_pin_oe) == 16'h0000; endproperty
  a_free_oe: assert property (p_free_oe) else $error("output without enable term is off");
  property p_eq_oe;
    ((cell_pin_oe ^ (pt_oe | direction_bits)) & cfg_cell_has_oe_eq & ~cfg_cell_node) == 16'h0000;
  endproperty
  a_eq_oe: assert property (p_eq_oe) else $error("pin enable is not term or direction");
  property p_fb; cell_feedback == cell_pin_out; endproperty
  a_fb: assert property (p_fb) else $error("feedback differs from cell output");
  // Read data only after the read strobe has crossed the synchronisers
  property p_rd;
    address_data_oe |-> !($past(bus_control_pin_1, 3) && $past(bus_control_pin_1, 4) && $past(bus_control_pin_1, 5));
  endproperty
  a_rd: assert property (p_rd) else $error("data driven without read strobe");
  property p_pin2; (cfg_bus_type == PMH_BUS_NO_FETCH && $stable(bus_control_pin_2))[*6] |-> control_pin_2_to_array == bus_control_pin_2; endproperty
  a_pin2: assert property (p_pin2) else $error("free control pin not passed to array");
  property p_pin2_mux; (cfg_bus_type == PMH_BUS_MUX)[*6] |-> !control_pin_2_to_array; endproperty
  a_pin2_mux: assert property (p_pin2_mux) else $error("fetch pin leaks into array");
  // With no write, no clock edge and no preset or clear, cells must hold
  property p_hold;
    (bus_control_pin_0 && !external_clock_input && cfg_cell_ext_clk == 16'hffff && cfg_cell_comb == 16'h0000
     && pt_preset == 16'h0000 && pt_clear == 16'h0000)[*7] |-> $stable(cell_pin_out);
  endproperty
  a_hold: assert property (p_hold) else $error("cell changed without a cause");
  property p_clear; bus_control_pin_0[*6] |=> (cell_pin_out & $past(pt_clear & ~cfg_cell_comb)) == 16'h0000; endproperty
  a_clear: assert property (p_clear) else $error("clear term did not clear");
  property p_preset;
    bus_control_pin_0[*6] ##0 pt_clear == 16'h0000 |=> (~cell_pin_out & $past(pt_preset & ~cfg_cell_comb)) == 16'h0000;
  endproperty
  a_preset: assert property (p_preset) else $error("preset term did not set");
  property p_expand; cell_expanded == over_lim; endproperty
  a_expand: assert property (p_expand) else $error("expansion flag wrong");
endmodule

// File: tb/pmh_host_model.sv
`timescale 1ns/1ns
// Host microcontroller on the multiplexed 8-bit bus
module pmh_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] address_data_out,
  input  wire logic       address_data_oe,
  output logic      [7:0] address_data_in,
  output logic      [7:0] address_high,
  output logic            address_strobe,
  output logic            bus_control_pin_0,
  output logic            bus_control_pin_1,
  output logic            bus_control_pin_2
);
  // Idle bus: strobes inactive, upper address on the window base
  initial begin
    address_data_in   = 8'h00;
    address_high      = 8'h00;
    address_strobe    = 1'b0;
    bus_control_pin_0 = 1'b1;
    bus_control_pin_1 = 1'b1;
    bus_control_pin_2 = 1'b1;
  end
  // Five cycles per address, write and idle phase so the pin synchronisers settle
  task automatic hold5();
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  task automatic set_pin2(input logic v);
    bus_control_pin_2 = v;
  endtask
  // One bus cycle: address phase, then write or read strobe
  task automatic access(input logic [7:0] off, input logic [7:0] wdata, input logic is_rd,
                        output logic [7:0] rdata, output logic oe);
    address_data_in = off;
    address_strobe  = 1'b1;
    hold5();
    address_strobe = 1'b0;
    hold5();
    if (is_rd) begin
      address_data_in   = ~off; // Released bus shows no stale value
      bus_control_pin_1 = 1'b0;
      repeat (7) @(posedge clk_sys);
      rdata = address_data_out;
      oe    = address_data_oe;
      #1;
      bus_control_pin_1 = 1'b1;
    end else begin
      address_data_in   = wdata;
      bus_control_pin_0 = 1'b0;
      hold5();
      bus_control_pin_0 = 1'b1;
    end
    hold5();
  endtask
endmodule

// File: tb/pmh_macrocell_host_tb_top.sv
`timescale 1ns/1ns
// Host sequences against the macrocell block
module pmh_macrocell_host_tb_top;
  import pmh_pkg::*;
  logic        clk_sys, resetn, external_clock_input, cfg_load_level, roe;
  logic        address_data_oe, address_strobe, bus_control_pin_0, bus_control_pin_1, bus_control_pin_2;
  logic        control_pin_2_to_array, program_fetch_active;
  logic [7:0]  address_data_in, address_data_out, address_high, rdat;
  logic [1:0]  cfg_bus_type;
  logic [15:0] cfg_cell_ext_clk, cfg_cell_has_oe_eq, cfg_cell_node, direction_bits, pt_d, pt_preset, pt_clear, pt_oe;
  logic [15:0] cell_pin_out, cell_pin_oe, cell_feedback, cell_expanded;
  logic [23:0] port_in, input_cell_out;
  logic [47:0] cfg_in_mode;
  logic [5:0]  cfg_in_use_strobe, pt_in_enable;
  logic [63:0] cfg_borrow_req;
  int          failures = 0;
  int          checked = 0;
  pmh_macrocell_host pmh_macrocell_host_inst (.clk_sys, .resetn, .address_data_in, .address_data_out,
    .address_data_oe, .address_high, .address_strobe, .bus_control_pin_0, .bus_control_pin_1, .bus_control_pin_2,
    .external_clock_input, .port_in, .cfg_bus_type, .cfg_load_level, .cfg_cell_comb(16'h0000), .cfg_cell_ext_clk,
    .cfg_cell_has_oe_eq, .cfg_cell_node, .direction_bits, .cfg_in_mode, .cfg_in_use_strobe, .cfg_borrow_req, .pt_d,
    .pt_clk(16'h0000), .pt_preset, .pt_clear, .pt_comb(16'h0000), .pt_oe, .pt_in_enable, .cell_pin_out, .cell_pin_oe,
    .cell_feedback, .input_cell_out, .control_pin_2_to_array, .program_fetch_active, .cell_expanded);
  pmh_host_model pmh_host_model_inst (.clk_sys, .address_data_out, .address_data_oe, .address_data_in,
    .address_high, .address_strobe, .bus_control_pin_0, .bus_control_pin_1, .bus_control_pin_2);
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pmh_host_model_inst.access(a, d, 1'b0, rdat, roe);
  endtask
  task automatic rd(input logic [7:0] a);
    pmh_host_model_inst.access(a, 8'h00, 1'b1, rdat, roe);
  endtask
  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Whole run needs about 3 us; a hang is cut well beyond that
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    resetn = 1'b0; external_clock_input = 1'b0; cfg_load_level = 1'b0; cfg_bus_type = 2'b00;
    cfg_cell_ext_clk = 16'hffff; cfg_cell_has_oe_eq = 16'hff00; cfg_cell_node = 16'h000f;
    direction_bits = 16'h3300; pt_oe = 16'h0f00; pt_d = 16'h0000; pt_preset = 16'h0000; pt_clear = 16'h0000;
    port_in = 24'h123456; cfg_in_mode = 48'h0; cfg_in_use_strobe = 6'h00; pt_in_enable = 6'h00;
    cfg_borrow_req = {16{4'h6}};
    tk(6);
    resetn = 1'b1;
    tk(5);
    rd(OFF_AB_MASK); chk(rdat, MASK_RESET);
    rd(OFF_BC_MASK); chk(rdat, MASK_RESET);
    rd(OFF_AB_CELLS); chk(rdat, CELLS_RESET);
    chk(cell_pin_oe, 16'h3ff0);
    chk(cell_expanded, 16'h0f00);
    chk(program_fetch_active, 1'b0);
    $display("test reset done");
    // Edge loads, mask on the low nibble, then a level load
    wr(OFF_AB_CELLS, 8'ha5); wr(OFF_BC_CELLS, 8'h3c);
    rd(OFF_AB_CELLS); chk(rdat, 8'ha5);
    chk(cell_pin_out, 16'h3ca5);
    chk(cell_feedback, 16'h3ca5);
    wr(OFF_AB_MASK, 8'h0f); rd(OFF_AB_MASK); chk(rdat, 8'h0f);
    wr(OFF_AB_CELLS, 8'h5a); rd(OFF_AB_CELLS); chk(rdat, 8'h55);
    cfg_load_level = 1'b1;
    wr(OFF_BC_CELLS, 8'h81); rd(OFF_BC_CELLS); chk(rdat, 8'h81);
    rd(8'h30); chk(roe, 1'b0);
    $display("test load done");
    // Clear, preset and the external clock
    pt_clear = 16'hffff; tk(1); pt_clear = 16'h0000; tk(1); chk(cell_pin_out, 16'h0000);
    pt_preset = 16'h00f0; tk(2); pt_preset = 16'h0000; chk(cell_pin_out, 16'h00f0);
    pt_d = 16'h5a5a; external_clock_input = 1'b1; tk(8);
    external_clock_input = 1'b0; chk(cell_pin_out, 16'h5a5a);
    $display("test terms done");
    // Pass, strobe latch on port C, term register on nibble 0
    rd(OFF_IN_PORT_A); chk(rdat, 8'h56);
    rd(OFF_IN_PORT_C); chk(rdat, 8'h12);
    chk(input_cell_out, 24'h123456);
    cfg_in_mode = {16'h5555, 24'h000000, 8'hff}; cfg_in_use_strobe = 6'b110000;
    port_in = 24'h9e3457;
    rd(OFF_IN_PORT_C); chk(rdat, 8'h9e);
    pt_in_enable = 6'h01; tk(6); pt_in_enable = 6'h00;
    port_in = 24'h11346a; tk(8);
    chk(input_cell_out, 24'h9e3467);
    $display("test inputs done");
    // Free control pin and borrow limits at their boundaries
    cfg_bus_type = 2'b11;
    pmh_host_model_inst.set_pin2(1'b0); tk(8); chk(control_pin_2_to_array, 1'b0);
    pmh_host_model_inst.set_pin2(1'b1); tk(8); chk(control_pin_2_to_array, 1'b1);
    // Fetch-only bus also leaves pin 2 free; idle pin 1 means no fetch
    cfg_bus_type = 2'b01; tk(1);
    chk(control_pin_2_to_array, 1'b1);
    chk(program_fetch_active, 1'b0);
    cfg_borrow_req = {32'h66665555, 32'h77777777}; tk(1);
    chk(cell_expanded, 16'h00ff);
    $display("test bus done");
    results();
  end
endmodule
bind pmh_macrocell_host pmh_macrocell_host_monitor pmh_macrocell_host_monitor_inst (.clk_sys, .resetn,
  .bus_control_pin_0, .bus_control_pin_1, .bus_control_pin_2, .external_clock_input, .address_data_oe,
  .control_pin_2_to_array, .cfg_bus_type, .cfg_cell_comb, .cfg_cell_ext_clk, .cfg_cell_has_oe_eq, .cfg_cell_node,
  .direction_bits, .pt_preset, .pt_clear, .pt_oe, .cell_pin_out, .cell_pin_oe, .cell_feedback, .cell_expanded,
  .cfg_borrow_req);
